/* File: logic/ctb_map.svh */
// byte offsets, field positions, reset values and timing of the counter timer
// register front end; assumes offsets are byte addresses with bit 0 as lane select
`ifndef CTB_MAP_SVH
`define CTB_MAP_SVH
`define CTB_OFS_BOARD     7'h00
`define CTB_OFS_PEND      7'h02
`define CTB_OFS_START     7'h04
`define CTB_OFS_HALT      7'h06
`define CTB_OFS_CTRL0     7'h08
`define CTB_OFS_READ0     7'h1c
`define CTB_OFS_CONA0     7'h30
`define CTB_OFS_CONB0     7'h44
`define CTB_OFS_DIN       7'h58
`define CTB_OFS_DOUT      7'h5a
`define CTB_OFS_VEC       7'h5c
`define CTB_BIT_CLKSEL    0
`define CTB_BIT_SWRST     15
`define CTB_BIT_IRQEN     15
`define CTB_ID_LSB        8
`define CTB_MODE_W        3
`define CTB_RST_CTRL      16'h0000
`define CTB_RST_CONST     16'h0000
`define CTB_RST_PEND      5'h00
`define CTB_RST_VEC       8'h00
`define CTB_RST_DOUT      3'h7
`define CTB_ACK_CYCLES    1
`endif

/* File: logic/ctb_pkg.sv */
// types shared by the counter timer register front end
// assumes ctb_map.svh holds all offsets and reset values
package ctb_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_WAIT} ctb_state_e;

    // one carrier i/o cycle as seen on the logic connector
    typedef struct packed {
        logic        iosel_n;  // i/o space select
        logic        rd;       // 1 = read, 0 = write
        logic [5:0]  addr;     // word address lines a6..a1
        logic [1:0]  bs_n;     // [1] high lane d15..d8, [0] low lane d7..d0
    } ctb_req_s;

    // whole register state of the front end
    typedef struct packed {
        ctb_state_e       st;
        logic             ack_n;
        logic             oe_n;
        logic [15:0]      rdata;
        logic             clk_sel;
        logic [4:0][15:0] ctrl;
        logic [4:0][15:0] cona;
        logic [4:0][15:0] conb;
        logic [4:0]       pend;
        logic [4:0]       start;
        logic [4:0]       halt;
        logic             swrst;
        logic [2:0]       dout;
        logic [7:0]       vec;
        logic             int_n;
    } ctb_state_s;

    // merge written lanes into an old value
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [15:0] wd,
                                               input logic [1:0]  bs_n);
        lane_merge = old;
        if (!bs_n[1]) begin
            lane_merge[15:8] = wd[15:8];
        end
        if (!bs_n[0]) begin
            lane_merge[7:0] = wd[7:0];
        end
    endfunction : lane_merge
endpackage : ctb_pkg

/* File: logic/ctb_host_regs.sv */
// register front end of a five channel 16-bit counter timer on the carrier i/o bus
// assumes bus inputs are synchronous to clk_sys; counter cores sit on the core ports
// Operation
// - reads of unassigned i/o locations return zero
// - high byte on even address lane, low byte on odd address lane
// - board control bit 0 selects 8 or 32 MHz carrier timing
// - power-up reset clears the carrier clock speed bit
// - board control bits 10..8 read a fixed model code, writes ignored
// - writing board control bit 15 resets the module, bit reads zero
// - unused board control bits read zero
// - pending bits 0..4 report counters 1..5, upper bits read zero
// - writing one clears a pending bit, zero leaves it alone
// - a still present cause sets the pending bit again
// - dropping a counter's interrupt enable releases its pending bit
// - counters without interrupt enable never set pending
// - reset clears all pending bits
// - trigger bit n starts counter n+1, nothing stored, reads zero
// - stop bit n clears counter n+1 mode field, nothing stored, reads zero
// - read-back returns live count sampled at the read, 16-bit only
// - constants a and b are read/write with 16-bit access only
// - system or software reset clears constants a and b
// - digital input bit 0 shows the input level, bits 1..7 zero
// - digital outputs follow written bits, read back, start at one
// - control, status, strobe and digital registers take byte and word access
// - reset clears every counter control register
`timescale 1ns/1ps
`include "ctb_map.svh"
module ctb_host_regs #(
    parameter logic [2:0] MODEL_CODE = 3'h2  // variant code, value arbitrary
) (
    input  wire logic                clk_sys,          // 100 MHz system clock
    input  wire logic                nrst,             // async reset, active low
    input  wire ctb_pkg::ctb_req_s   bus_req,          // carrier i/o cycle
    input  wire logic [15:0]         data_in,          // data pins, input side
    output logic      [15:0]         data_out,         // data pins, output side
    output logic                     data_oe_n,        // low while driving data
    output logic                     ack_n,            // cycle acknowledge
    output logic                     int_req_n,        // any interrupt pending
    input  wire logic [4:0]          irq_cause,        // per counter cause level
    input  wire logic [4:0][15:0]    count_value,      // live counts
    input  wire logic                differential_input_one, // digital input
    output logic                     differential_output_one, // digital out 1
    output logic                     differential_output_two, // digital out 2
    output logic                     differential_output_three, // digital out 3
    output logic                     clk_speed_sel,    // 1 = 32 MHz carrier
    output logic [4:0][15:0]         ctrl_word,        // counter control words
    output logic [4:0][15:0]         initial_constant_a, // constants a
    output logic [4:0][15:0]         reload_constant_b,  // constants b
    output logic [4:0]               start_strobe,     // one-clock trigger
    output logic [4:0]               halt_strobe,      // one-clock stop
    output logic                     soft_reset,       // one-clock module reset
    output logic [7:0]               interrupt_vector  // vector for int cycles
);
    ctb_pkg::ctb_state_s s_q;
    ctb_pkg::ctb_state_s s_d;

    logic [6:0]  ofs;
    logic [2:0]  idx;
    logic        word;
    logic [15:0] rd;
    logic [15:0] bc;

    // outputs straight from state flops
    assign data_out                  = s_q.rdata;
    assign data_oe_n                 = s_q.oe_n;
    assign ack_n                     = s_q.ack_n;
    assign int_req_n                 = s_q.int_n;
    assign differential_output_one   = s_q.dout[0];
    assign differential_output_two   = s_q.dout[1];
    assign differential_output_three = s_q.dout[2];
    assign clk_speed_sel             = s_q.clk_sel;
    assign ctrl_word                 = s_q.ctrl;
    assign initial_constant_a        = s_q.cona;
    assign reload_constant_b         = s_q.conb;
    assign start_strobe              = s_q.start;
    assign halt_strobe               = s_q.halt;
    assign soft_reset                = s_q.swrst;
    assign interrupt_vector          = s_q.vec;

    // decode helpers: byte offset and both-lane flag
    assign ofs  = {bus_req.addr, 1'b0};
    assign word = (bus_req.bs_n == 2'b00);

    // next state: bus cycle, register writes, pending logic, soft reset
    always_comb begin
        s_d       = s_q;
        s_d.start = 5'h00;
        s_d.halt  = 5'h00;
        s_d.swrst = 1'b0;
        s_d.ack_n = 1'b1;
        s_d.oe_n  = 1'b1;
        rd        = 16'h0000;  // unmapped locations read zero
        idx       = 3'h0;
        bc        = 16'h0000;
        bc[`CTB_BIT_CLKSEL] = s_q.clk_sel;
        bc[`CTB_ID_LSB +: 3] = MODEL_CODE;    // other bits zero
        case (s_q.st)
            ctb_pkg::ST_IDLE: begin
                if (!bus_req.iosel_n) begin
                    s_d.st    = ctb_pkg::ST_ACK;
                    s_d.ack_n = 1'b0;
                    if (bus_req.rd) begin
                        // lanes: d15..d8 even byte, d7..d0 odd byte
                        if (ofs == `CTB_OFS_BOARD) begin
                            rd = bc;
                        end else if (ofs == `CTB_OFS_PEND) begin
                            rd = {11'h000, s_q.pend};
                        end else if (ofs == `CTB_OFS_DIN) begin
                            rd = {15'h0000, differential_input_one};
                        end else if (ofs == `CTB_OFS_DOUT) begin
                            rd = {13'h0000, s_q.dout};
                        end else if (ofs == `CTB_OFS_VEC) begin
                            rd = {8'h00, s_q.vec};
                        end
                        // trigger and stop fall through as zero
                        for (int i = 0; i < 5; i++) begin
                            idx = 3'(i);
                            if (ofs == `CTB_OFS_CTRL0 + 7'({idx, 1'b0})) begin
                                rd = s_q.ctrl[i];
                            end
                            if (ofs == `CTB_OFS_READ0 + 7'({idx, 1'b0})) begin
                                rd = count_value[i];   // sampled now
                            end
                            if (ofs == `CTB_OFS_CONA0 + 7'({idx, 1'b0})) begin
                                rd = s_q.cona[i];
                            end
                            if (ofs == `CTB_OFS_CONB0 + 7'({idx, 1'b0})) begin
                                rd = s_q.conb[i];
                            end
                        end
                        s_d.rdata = rd;
                        s_d.oe_n  = 1'b0;
                    end else begin
                        // byte or word writes accepted here
                        if (ofs == `CTB_OFS_BOARD) begin
                            if (!bus_req.bs_n[0]) begin
                                s_d.clk_sel = data_in[`CTB_BIT_CLKSEL];
                            end
                            if (!bus_req.bs_n[1] && data_in[`CTB_BIT_SWRST]) begin
                                s_d.swrst = 1'b1;
                            end
                        end else if (ofs == `CTB_OFS_START) begin
                            if (!bus_req.bs_n[0]) begin
                                s_d.start = data_in[4:0];
                            end
                        end else if (ofs == `CTB_OFS_HALT) begin
                            if (!bus_req.bs_n[0]) begin
                                s_d.halt = data_in[4:0];
                            end
                        end else if (ofs == `CTB_OFS_DOUT) begin
                            if (!bus_req.bs_n[0]) begin
                                s_d.dout = data_in[2:0];
                            end
                        end else if (ofs == `CTB_OFS_VEC) begin
                            if (!bus_req.bs_n[0]) begin
                                s_d.vec = data_in[7:0];
                            end
                        end
                        for (int i = 0; i < 5; i++) begin
                            idx = 3'(i);
                            if (ofs == `CTB_OFS_CTRL0 + 7'({idx, 1'b0})) begin
                                s_d.ctrl[i] = ctb_pkg::lane_merge(s_q.ctrl[i],
                                                                  data_in, bus_req.bs_n);
                            end
                            // byte writes to constants are dropped
                            if (word && ofs == `CTB_OFS_CONA0 + 7'({idx, 1'b0})) begin
                                s_d.cona[i] = data_in;
                            end
                            if (word && ofs == `CTB_OFS_CONB0 + 7'({idx, 1'b0})) begin
                                s_d.conb[i] = data_in;
                            end
                        end
                    end
                end
            end
            ctb_pkg::ST_ACK: begin
                // one acknowledged cycle, then wait for select to drop
                s_d.st = ctb_pkg::ST_WAIT;
            end
            ctb_pkg::ST_WAIT: begin
                if (bus_req.iosel_n) begin
                    s_d.st = ctb_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.st = ctb_pkg::ST_IDLE;
            end
        endcase

        // stop clears mode field of selected counters
        for (int i = 0; i < 5; i++) begin
            if (s_d.halt[i]) begin
                s_d.ctrl[i][`CTB_MODE_W-1:0] = 3'h0;
            end
        end

        // pending: clear on write one, cause wins over clear, gated by enable
        if (s_q.st == ctb_pkg::ST_IDLE && !bus_req.iosel_n && !bus_req.rd &&
            ofs == `CTB_OFS_PEND && !bus_req.bs_n[0]) begin
            s_d.pend = s_q.pend & ~data_in[4:0];
        end
        for (int i = 0; i < 5; i++) begin
            // re-arm while cause holds, enable gates
            s_d.pend[i] = (s_d.pend[i] | irq_cause[i]) & s_d.ctrl[i][`CTB_BIT_IRQEN];
        end

        // software reset: everything but the clock speed bit
        if (s_d.swrst) begin
            s_d.ctrl = {5{`CTB_RST_CTRL}};
            s_d.cona = {5{`CTB_RST_CONST}};
            s_d.conb = {5{`CTB_RST_CONST}};
            s_d.pend = `CTB_RST_PEND;
            s_d.dout = `CTB_RST_DOUT;
            s_d.vec  = `CTB_RST_VEC;
            s_d.start = 5'h00;
        end
        s_d.int_n = ~|s_d.pend;
    end

    // state register; power-up reset clears clock speed and pending
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_q.st      <= ctb_pkg::ST_IDLE;
            s_q.ack_n   <= 1'b1;
            s_q.oe_n    <= 1'b1;
            s_q.rdata   <= 16'h0000;
            s_q.clk_sel <= 1'b0;
            s_q.ctrl    <= {5{`CTB_RST_CTRL}};
            s_q.cona    <= {5{`CTB_RST_CONST}};
            s_q.conb    <= {5{`CTB_RST_CONST}};
            s_q.pend    <= `CTB_RST_PEND;
            s_q.start   <= 5'h00;
            s_q.halt    <= 5'h00;
            s_q.swrst   <= 1'b0;
            s_q.dout    <= `CTB_RST_DOUT;
            s_q.vec     <= `CTB_RST_VEC;
            s_q.int_n   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : ctb_host_regs

/* File: verif/ctb_host_regs_assertions.sv */
// port assertions for the counter timer register front end
// assumes a host that holds select until ack, then idles a cycle
`timescale 1ns/1ps
module ctb_host_regs_assertions (
    input wire logic              clk_sys,      // clock
    input wire logic              nrst,         // reset
    input wire ctb_pkg::ctb_req_s bus_req,      // host cycle
    input wire logic              ack_n,        // ack
    input wire logic              data_oe_n,    // read drive
    input wire logic              int_req_n,    // irq
    input wire logic [4:0]        irq_cause,    // causes
    input wire logic [4:0][15:0]  ctrl_word,    // controls
    input wire logic [4:0]        start_strobe, // trigger
    input wire logic [4:0]        halt_strobe,  // stop
    input wire logic              soft_reset    // sw reset
);
    logic [4:0] en;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // per counter enables and the stop effect on the mode field
    for (genvar i = 0; i < 5; i++) begin : g_ch
        assign en[i] = ctrl_word[i][15];
        a_halt_mode: assert property (halt_strobe[i] |-> ctrl_word[i][2:0] == 3'h0)
            else $error("stop left mode bits set");
    end
    // each take answered one edge later by a one-cycle ack
    a_take_ack: assert property ($fell(bus_req.iosel_n) |=> !ack_n ##1 ack_n)
        else $error("ack not one cycle after take");
    a_read_drive: assert property ($fell(bus_req.iosel_n) && bus_req.rd |=> !data_oe_n)
        else $error("read not driven with ack");
    // strobes only inside a write ack, trigger strobe one cycle wide
    a_strobe_ack: assert property (|{start_strobe, halt_strobe} |-> !ack_n && !bus_req.rd)
        else $error("strobe outside write ack");
    a_strobe_pulse: assert property (|start_strobe |=> start_strobe == 5'h00)
        else $error("trigger strobe too long");
    // two cycles of enable so either ctrl timing is accepted
    a_cause_pend: assert property (irq_cause[0] && en[0] ##1 en[0] |-> !int_req_n)
        else $error("enabled cause not pending");
    a_off_quiet: assert property ((en == 5'h00) [*2] |-> int_req_n)
        else $error("interrupt without enable");
    a_reset_vals: assert property ($rose(nrst) |-> int_req_n && ctrl_word == 80'h0)
        else $error("bad values after reset");
    a_soft_clear: assert property (soft_reset |-> !ack_n && ctrl_word == 80'h0)
        else $error("control kept over soft reset");
    c_start: cover property (|start_strobe);
    c_soft: cover property (soft_reset);
    c_irq: cover property (!int_req_n);
endmodule : ctb_host_regs_assertions
bind ctb_host_regs ctb_host_regs_assertions u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .ack_n(ack_n),
    .data_oe_n(data_oe_n), .int_req_n(int_req_n), .irq_cause(irq_cause),
    .ctrl_word(ctrl_word), .start_strobe(start_strobe), .halt_strobe(halt_strobe),
    .soft_reset(soft_reset));

/* File: verif/ctb_host_model.sv */
// carrier host bus controller model issuing i/o cycles
// assumes the bench calls access and sets gap for slow hosts
`timescale 1ns/1ps
module ctb_host_model (
    input  wire logic        clk_sys,  // clock
    input  wire logic [1:0]  gap,      // idle edges first
    output ctb_pkg::ctb_req_s bus_req, // i/o cycle
    output logic [15:0]      data_in,  // write data
    input  wire logic [15:0] data_out, // read data
    input  wire logic        ack_n     // acknowledge
);
    // idle bus at time zero
    initial begin
        bus_req = '{iosel_n: 1'b1, rd: 1'b1, addr: 6'h3f, bs_n: 2'h3};
        data_in = 16'h5a5a;
    end
    // held until ack sampled low or eight edges pass; released data flips so no stale value shows
    task automatic access(input logic r, input logic [6:0] o, input logic [1:0] b,
                          input logic [15:0] w, output logic [15:0] rv, output logic to);
        int n;
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        bus_req <= '{iosel_n: 1'b0, rd: r, addr: o[6:1], bs_n: b};
        data_in <= r ? ~data_in : w;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack_n !== 1'b0 && n < 8);
        rv = data_out;
        to = (ack_n !== 1'b0);
        bus_req.iosel_n <= 1'b1;
        data_in <= ~data_in;
    endtask : access
endmodule : ctb_host_model

/* File: verif/tb_ctb_host_regs.sv */
// self-checking bench for the counter timer register front end
// assumes the host model runs bus cycles and the checker is bound in
`timescale 1ns/1ps
`include "ctb_map.svh"
module tb_ctb_host_regs;
    localparam logic [2:0] CODE = 3'h5; // value arbitrary
    // unassigned word offsets spread over every hole of the i/o space
    localparam logic [6:0] HOLE [6] = '{7'h12, 7'h26, 7'h3a, 7'h4e, 7'h5e, 7'h7e};
    logic              clk_sys = 1'b0;
    logic              nrst = 1'b0;
    logic              din = 1'b1;
    logic              oe_n, ack_n, irq, spd, to, sr_s, sr_v;
    logic [1:0]        gap = 2'h0;
    logic [2:0]        dout;
    logic [4:0]        cause = 5'h00;
    logic [4:0]        st_s, hl_s, st_v, hl_v;
    logic [7:0]        vec;
    logic [15:0]       din_w, dout_w, rv;
    logic [31:0]       lfsr = 32'h774c3767;
    logic [4:0][15:0]  cnt = 80'h0;
    logic [4:0][15:0]  ctrl, ca, cb;
    logic [15:0]       exq[$];
    ctb_pkg::ctb_req_s req;
    int                err_total = 0;
    int                checked = 0;
    ctb_host_regs #(.MODEL_CODE(CODE)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .bus_req(req), .data_in(din_w),
        .data_out(dout_w), .data_oe_n(oe_n), .ack_n(ack_n), .int_req_n(irq),
        .irq_cause(cause), .count_value(cnt), .differential_input_one(din),
        .differential_output_one(dout[0]), .differential_output_two(dout[1]),
        .differential_output_three(dout[2]), .clk_speed_sel(spd), .ctrl_word(ctrl),
        .initial_constant_a(ca), .reload_constant_b(cb), .start_strobe(st_s),
        .halt_strobe(hl_s), .soft_reset(sr_s), .interrupt_vector(vec));
    ctb_host_model u_host (.clk_sys(clk_sys), .gap(gap), .bus_req(req), .data_in(din_w),
        .data_out(dout_w), .ack_n(ack_n));
    always #5 clk_sys = ~clk_sys;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    function automatic logic [6:0] at(input logic [6:0] b, input int i);
        at = b + 7'(2 * i);
    endfunction : at
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // random idle gap so the host is sometimes slow
    task automatic wr(input logic [6:0] o, input logic [1:0] b, input logic [15:0] w);
        gap <= lfsr[1:0];
        lfsr = nxt(lfsr);
        u_host.access(1'b0, o, b, w, rv, to);
        cmp("ack", 16'h0, {15'h0, to});
    endtask : wr
    task automatic rd(input logic [6:0] o, input logic [15:0] e);
        exq.push_back(e);
        u_host.access(1'b1, o, 2'h0, 16'h0, rv, to);
        cmp("ack", 16'h0, {15'h0, to});
    endtask : rd
    task automatic results();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    // watcher: strobes and read data seen with each ack
    always @(posedge clk_sys) begin
        if (ack_n === 1'b0) begin
            st_v = st_s;
            hl_v = hl_s;
            sr_v = sr_s;
            if (oe_n === 1'b0) begin
                cmp("read", exq.pop_front(), dout_w);
            end
        end
    end
    initial begin : main
        logic [15:0] v;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        cmp("speed", 16'h0, {15'h0, spd});
        cmp("dout", 16'h7, {13'h0, dout});
        for (int i = 0; i < 5; i++) begin
            rd(at(`CTB_OFS_CONB0, i), 16'h0);
        end
        rd(`CTB_OFS_PEND, 16'h0);
        $display("reset test done");
        // low byte of a word write would soft reset if lanes were swapped
        wr(`CTB_OFS_BOARD, 2'h0, 16'h7fff);
        rd(`CTB_OFS_BOARD, {5'h0, CODE, 8'h01});
        cmp("speed", 16'h1, {15'h0, spd});
        wr(`CTB_OFS_BOARD, 2'h2, 16'hff00);
        rd(`CTB_OFS_BOARD, {5'h0, CODE, 8'h00});
        wr(`CTB_OFS_CTRL0, 2'h1, 16'h12ab);
        wr(`CTB_OFS_CTRL0, 2'h2, 16'hcd34);
        cmp("ctrl", 16'h1234, ctrl[0]);
        $display("board test done");
        for (int i = 0; i < 5; i++) begin
            wr(at(`CTB_OFS_CTRL0, i), 2'h0, 16'h1235);
            wr(`CTB_OFS_START, 2'h0, 16'(1 << i));
            #1 cmp("start", 16'(1 << i), {11'h0, st_v});
            wr(`CTB_OFS_HALT, 2'h0, 16'(1 << i));
            #1 cmp("halt", 16'(1 << i), {11'h0, hl_v});
            cmp("mode", 16'h1230, ctrl[i]);
            v = lfsr[15:0];
            lfsr = nxt(lfsr);
            wr(at(`CTB_OFS_CONA0, i), 2'h0, v);
            wr(at(`CTB_OFS_CONA0, i), 2'h2, ~v);
            wr(at(`CTB_OFS_CONB0, i), 2'h0, ~v);
            rd(at(`CTB_OFS_CONA0, i), v);
            cmp("const b", ~v, cb[i]);
        end
        rd(`CTB_OFS_START, 16'h0);
        rd(`CTB_OFS_HALT, 16'h0);
        wr(`CTB_OFS_DOUT, 2'h0, 16'h0002);
        cmp("dout", 16'h2, {13'h0, dout});
        rd(`CTB_OFS_DOUT, 16'h2);
        wr(`CTB_OFS_BOARD, 2'h0, 16'h8000);
        #1 cmp("soft", 16'h1, {15'h0, sr_v});
        cmp("dout", 16'h7, {13'h0, dout});
        cmp("const a", 16'h0, ca[4]);
        rd(`CTB_OFS_BOARD, {5'h0, CODE, 8'h00});
        rd(at(`CTB_OFS_CTRL0, 4), 16'h0);
        $display("strobe test done");
        for (int i = 0; i < 5; i++) begin
            wr(at(`CTB_OFS_CTRL0, i), 2'h0, 16'h8000);
            cause <= 5'(1 << i);
            @(posedge clk_sys);
            cause <= 5'h00;
            rd(`CTB_OFS_PEND, 16'(1 << i));
            cmp("irq", 16'h0, {15'h0, irq});
            wr(`CTB_OFS_PEND, 2'h0, 16'h0000);
            rd(`CTB_OFS_PEND, 16'(1 << i));
            wr(`CTB_OFS_PEND, 2'h0, 16'hffff);
            rd(`CTB_OFS_PEND, 16'h0);
            cause <= 5'(1 << i);
            wr(`CTB_OFS_PEND, 2'h0, 16'hffff);
            rd(`CTB_OFS_PEND, 16'(1 << i));
            wr(at(`CTB_OFS_CTRL0, i), 2'h0, 16'h0000);
            rd(`CTB_OFS_PEND, 16'h0);
            cause <= 5'h00;
        end
        $display("pending test done");
        for (int i = 0; i < 5; i++) begin
            cnt[i] <= lfsr[31:16];
            rd(at(`CTB_OFS_READ0, i), lfsr[31:16]);
            lfsr = nxt(lfsr);
            din <= i[0];
            rd(`CTB_OFS_DIN, {15'h0, i[0]});
        end
        wr(`CTB_OFS_VEC, 2'h0, 16'h00c3);
        cmp("vector", 16'h00c3, {8'h0, vec});
        rd(`CTB_OFS_VEC, 16'h00c3);
        wr(7'h5e, 2'h0, 16'hffff);
        for (int k = 0; k < 6; k++) begin
            rd(HOLE[k], 16'h0);
        end
        rd(7'h12, 16'h0);
        rd(7'h4e, 16'h0);
        rd(7'h5e, 16'h0);
        $display("readback test done");
        results();
    end
    // watchdog well beyond the few hundred cycles the tests take
    initial begin
        #200000;
        err_total++;
        $display("mismatch watchdog expected done seen timeout");
        results();
    end
endmodule : tb_ctb_host_regs
